// >>> oamd_decoder.sv
`timescale 1ns/100ps
`default_nettype none

module oamd_decoder (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Decode request from the opcode predecoder
	input wire logic start_i,
	input wire oamd_pkg::oamd_mode_t mode_i,
	input wire logic use_y_i,
	input wire logic rmw_i,
	input wire oamd_pkg::oamd_inh_t inh_kind_i,
	// Index registers and next-instruction PC
	input wire logic [7:0] x_i,
	input wire logic [7:0] y_i,
	input wire logic [15:0] pc_i,
	// Instruction byte stream
	input wire logic fetch_valid_i,
	input wire logic [7:0] fetch_byte_i,
	output logic fetch_req_o,
	// Page-zero pointer read port
	input wire logic ptr_valid_i,
	input wire logic [7:0] ptr_data_i,
	output logic ptr_rd_o,
	output logic [15:0] ptr_addr_o,
	// Decode result
	output logic busy_o,
	output logic done_o,
	output logic illegal_o,
	output oamd_pkg::oamd_family_t family_o,
	output logic [2:0] length_o,
	output logic [7:0] operand_o,
	output logic [15:0] ea_o,
	output logic [15:0] target_o,
	output logic wait_for_interrupt_op_o,
	output logic halt_op_o
);
	import oamd_pkg::*;

	// -------------------------------------------------------------
	// Types and state
	// -------------------------------------------------------------
	// Gray sequence along idle, operands, pointer, calc, done
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OPND = 3'b001,
		ST_PTR = 3'b011,
		ST_CALC = 3'b010,
		ST_DONE = 3'b110
	} oamd_state_t;

	typedef struct packed {
		oamd_state_t st;
		oamd_mode_t mode;
		logic use_y;
		logic illegal;
		logic [1:0] cnt;
		logic [7:0] opnd0;
		logic [7:0] opnd1;
		logic [15:0] ptr;
		logic ptr_rd;
		logic [15:0] ptr_addr;
		logic fetch_req;
		logic done;
		logic [2:0] len;
		oamd_family_t family;
		logic wait_int;
		logic halt;
		logic busy;
		logic [7:0] operand;
		logic [15:0] ea;
		logic [15:0] target;
	} oamd_regs_t;

	oamd_regs_t s_reg;
	oamd_regs_t s_next;
	oamd_calc_in_t calc_in;
	oamd_calc_out_t calc_out;
	oamd_info_t info;

	// -------------------------------------------------------------
	// Decode functions
	// -------------------------------------------------------------
	// Static properties of a mode
	function automatic oamd_info_t mode_info(input oamd_mode_t m);
		oamd_info_t r;
		r = '0;
		case (m)
			OAMD_INH: r.opnd_bytes = 2'd0;
			OAMD_IMM: r.opnd_bytes = 2'd1;
			OAMD_DIR_S: r.opnd_bytes = 2'd1;
			OAMD_DIR_L: begin
				r.opnd_bytes = 2'd2;
				r.long_form = 1'b1;
			end
			OAMD_IDX0: r.indexed = 1'b1;
			OAMD_IDX_S: begin
				r.opnd_bytes = 2'd1;
				r.indexed = 1'b1;
			end
			OAMD_IDX_L: begin
				r.opnd_bytes = 2'd2;
				r.indexed = 1'b1;
				r.long_form = 1'b1;
			end
			OAMD_IND_S, OAMD_BIT_I: begin
				r = '{2'd1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
			end
			OAMD_IND_L: r = '{2'd1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
			OAMD_IIDX_S: r = '{2'd1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
			OAMD_IIDX_L: r = '{2'd1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
			OAMD_REL_D: begin
				r.opnd_bytes = 2'd1;
				r.relative = 1'b1;
			end
			OAMD_REL_I: r = '{2'd1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
			OAMD_BIT_D: r.opnd_bytes = 2'd1;
			OAMD_BITREL_D: begin
				r.opnd_bytes = 2'd2;
				r.relative = 1'b1;
			end
			OAMD_BITREL_I: r = '{2'd2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
			default: r = '0;
		endcase
		return r;
	endfunction : mode_info

	// Family of a mode
	function automatic oamd_family_t mode_family(input oamd_mode_t m);
		case (m)
			OAMD_INH: mode_family = OAMD_FAM_INH;
			OAMD_IMM: mode_family = OAMD_FAM_IMM;
			OAMD_DIR_S, OAMD_DIR_L: mode_family = OAMD_FAM_DIR;
			OAMD_IDX0, OAMD_IDX_S, OAMD_IDX_L: mode_family = OAMD_FAM_IDX;
			OAMD_IND_S, OAMD_IND_L, OAMD_IIDX_S, OAMD_IIDX_L: mode_family = OAMD_FAM_IND;
			OAMD_REL_D, OAMD_REL_I: mode_family = OAMD_FAM_REL;
			default: mode_family = OAMD_FAM_BIT;
		endcase
	endfunction : mode_family

	// -------------------------------------------------------------
	// Address calculator
	// -------------------------------------------------------------
	assign info = mode_info(s_reg.mode);
	assign calc_in = '{s_reg.mode, s_reg.opnd0, s_reg.opnd1, s_reg.ptr,
		(s_reg.use_y ? y_i : x_i)};

	oamd_ea_calc u_ea_calc (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.calc_i(calc_in),
		.pc_i(pc_i),
		.calc_o(calc_out)
	);

	// -------------------------------------------------------------
	// Sequencer
	// -------------------------------------------------------------
	// Collects operand bytes, reads the pointer, then waits one calc cycle
	always_comb begin
		oamd_info_t ni;
		ni = mode_info(mode_i);
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.wait_int = 1'b0;
		s_next.halt = 1'b0;
		s_next.ptr_rd = 1'b0;
		s_next.fetch_req = 1'b0;
		case (s_reg.st)
			ST_IDLE: begin
				if (start_i) begin
					s_next.mode = mode_i;
					s_next.use_y = use_y_i;
					s_next.family = mode_family(mode_i);
					s_next.cnt = OAMD_CNT_RESET;
					s_next.ptr = OAMD_EA_RESET;
					s_next.opnd0 = OAMD_BYTE_RESET;
					s_next.opnd1 = OAMD_BYTE_RESET;
					// Prefix byte counted for indirect forms and for Y indexed forms
					s_next.len = {1'b0, ni.opnd_bytes} +
						{2'b00, ni.indirect | (ni.indexed & use_y_i)};
					// Long form on a read-modify-write op: refuse without fetching
					s_next.illegal = rmw_i & ni.long_form;
					if (rmw_i & ni.long_form) begin
						s_next.st = ST_CALC;
					end else if (ni.opnd_bytes != 2'd0) begin
						s_next.st = ST_OPND;
						s_next.fetch_req = 1'b1;
					end else begin
						s_next.st = ST_CALC;
					end
				end
			end
			ST_OPND: begin
				s_next.fetch_req = 1'b1;
				if (fetch_valid_i) begin
					// First byte is the high one for long addresses
					if (s_reg.cnt == 2'd0) begin
						s_next.opnd0 = fetch_byte_i;
					end else begin
						s_next.opnd1 = fetch_byte_i;
					end
					s_next.cnt = s_reg.cnt + 2'd1;
					if (s_reg.cnt + 2'd1 == info.opnd_bytes) begin
						s_next.fetch_req = 1'b0;
						s_next.cnt = OAMD_CNT_RESET;
						if (info.ptr_used) begin
							s_next.st = ST_PTR;
							s_next.ptr_rd = 1'b1;
							s_next.ptr_addr = {OAMD_PAGE_ZERO_HI,
								(s_reg.cnt == 2'd0) ? fetch_byte_i : s_reg.opnd0};
						end else begin
							s_next.st = ST_CALC;
						end
					end
				end
			end
			ST_PTR: begin
				if (ptr_valid_i) begin
					// Word pointer: high byte at the pointer address, low byte next
					s_next.ptr = {s_reg.ptr[7:0], ptr_data_i};
					if (info.ptr_word && s_reg.cnt == 2'd0) begin
						s_next.cnt = 2'd1;
						s_next.ptr_rd = 1'b1;
						// Stays in page zero; wraps at 00FFh
						s_next.ptr_addr = {OAMD_PAGE_ZERO_HI, s_reg.ptr_addr[7:0] + 8'h01};
					end else begin
						s_next.st = ST_CALC;
					end
				end
			end
			ST_CALC: begin
				s_next.st = ST_DONE;
			end
			ST_DONE: begin
				s_next.st = ST_IDLE;
				s_next.done = 1'b1;
				s_next.operand = s_reg.opnd0;
				// A refused long form reports a zero address, not a partial sum
				s_next.ea = s_reg.illegal ? OAMD_EA_RESET : calc_out.ea;
				s_next.target = calc_out.target;
				if (s_reg.mode == OAMD_INH) begin
					s_next.wait_int = (inh_kind_i == OAMD_INH_WAIT_INT);
					s_next.halt = (inh_kind_i == OAMD_INH_HALT);
				end
			end
			default: begin
				s_next.st = ST_IDLE;
			end
		endcase
		s_next.busy = (s_next.st != ST_IDLE); // Registered so busy_o leaves a flop
	end

	// State register
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			s_reg <= '{ST_IDLE, OAMD_INH, 1'b0, 1'b0, OAMD_CNT_RESET, OAMD_BYTE_RESET,
				OAMD_BYTE_RESET, OAMD_EA_RESET, 1'b0, OAMD_EA_RESET, 1'b0, 1'b0,
				OAMD_LEN_RESET, OAMD_FAM_INH, 1'b0, 1'b0, 1'b0, OAMD_BYTE_RESET,
				OAMD_EA_RESET, OAMD_EA_RESET};
		end else begin
			s_reg <= s_next;
		end
	end

	// -------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------
	assign fetch_req_o = s_reg.fetch_req;
	assign ptr_rd_o = s_reg.ptr_rd;
	assign ptr_addr_o = s_reg.ptr_addr;
	assign busy_o = s_reg.busy;
	assign done_o = s_reg.done;
	assign illegal_o = s_reg.illegal;
	assign family_o = s_reg.family;
	assign length_o = s_reg.len;
	assign operand_o = s_reg.operand;
	assign ea_o = s_reg.ea;
	assign target_o = s_reg.target;
	assign wait_for_interrupt_op_o = s_reg.wait_int;
	assign halt_op_o = s_reg.halt;

endmodule : oamd_decoder

`default_nettype wire

// >>> oamd_pkg.sv
package oamd_pkg;

	// -------------------------------------------------------------
	// Addressing modes
	// -------------------------------------------------------------
	// Seventeen modes, short and long forms kept side by side
	typedef enum logic [4:0] {
		OAMD_INH      = 5'h00,
		OAMD_IMM      = 5'h01,
		OAMD_DIR_S    = 5'h02,
		OAMD_DIR_L    = 5'h03,
		OAMD_IDX0     = 5'h04,
		OAMD_IDX_S    = 5'h05,
		OAMD_IDX_L    = 5'h06,
		OAMD_IND_S    = 5'h07,
		OAMD_IND_L    = 5'h08,
		OAMD_IIDX_S   = 5'h09,
		OAMD_IIDX_L   = 5'h0A,
		OAMD_REL_D    = 5'h0B,
		OAMD_REL_I    = 5'h0C,
		OAMD_BIT_D    = 5'h0D,
		OAMD_BIT_I    = 5'h0E,
		OAMD_BITREL_D = 5'h0F,
		OAMD_BITREL_I = 5'h10
	} oamd_mode_t;

	localparam int unsigned OAMD_MODE_COUNT = 17;

	// Seven mode families
	typedef enum logic [2:0] {
		OAMD_FAM_INH = 3'h0,
		OAMD_FAM_IMM = 3'h1,
		OAMD_FAM_DIR = 3'h2,
		OAMD_FAM_IDX = 3'h3,
		OAMD_FAM_IND = 3'h4,
		OAMD_FAM_REL = 3'h5,
		OAMD_FAM_BIT = 3'h6
	} oamd_family_t;

	// Inherent operations of interest to power management
	typedef enum logic [1:0] {
		OAMD_INH_OTHER = 2'h0,
		OAMD_INH_WAIT_INT = 2'h1,
		OAMD_INH_HALT = 2'h2
	} oamd_inh_t;

	// -------------------------------------------------------------
	// Constants
	// -------------------------------------------------------------
	localparam logic [7:0] OAMD_PAGE_ZERO_HI = 8'h00;
	localparam logic [15:0] OAMD_EA_RESET = 16'h0000;
	localparam logic [7:0] OAMD_BYTE_RESET = 8'h00;
	localparam logic [1:0] OAMD_CNT_RESET = 2'h0;
	localparam logic [2:0] OAMD_LEN_RESET = 3'h0;

	// -------------------------------------------------------------
	// Carriers
	// -------------------------------------------------------------
	// Per-mode static properties
	typedef struct packed {
		logic [1:0] opnd_bytes;
		logic ptr_used;
		logic ptr_word;
		logic long_form;
		logic indexed;
		logic relative;
		logic indirect;
	} oamd_info_t;

	// Operands handed to the address calculator
	typedef struct packed {
		oamd_mode_t mode;
		logic [7:0] opnd0;
		logic [7:0] opnd1;
		logic [15:0] ptr;
		logic [7:0] index;
	} oamd_calc_in_t;

	// Result of the address calculator
	typedef struct packed {
		logic [15:0] ea;
		logic [15:0] target;
	} oamd_calc_out_t;

endpackage : oamd_pkg

// >>> oamd_ea_calc.sv
`timescale 1ns/100ps
`default_nettype none

module oamd_ea_calc (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Operands and program counter
	input wire oamd_pkg::oamd_calc_in_t calc_i,
	input wire logic [15:0] pc_i,
	// Registered result
	output oamd_pkg::oamd_calc_out_t calc_o
);
	import oamd_pkg::*;

	oamd_calc_out_t state_reg;
	oamd_calc_out_t state_next;

	// Sign-extend an 8-bit displacement onto the next-instruction PC
	function automatic logic [15:0] rel_add(input logic [15:0] pc, input logic [7:0] disp);
		rel_add = pc + {{8{disp[7]}}, disp};
	endfunction : rel_add

	// -------------------------------------------------------------
	// Address formation
	// -------------------------------------------------------------
	// Index adds are unsigned and zero extended, so short sums top out at 1FEh
	always_comb begin
		state_next.target = OAMD_EA_RESET;
		case (calc_i.mode)
			OAMD_DIR_S, OAMD_BIT_D, OAMD_BITREL_D: begin
				state_next.ea = {OAMD_PAGE_ZERO_HI, calc_i.opnd0};
			end
			OAMD_DIR_L: begin
				state_next.ea = {calc_i.opnd0, calc_i.opnd1};
			end
			OAMD_IDX0: begin
				state_next.ea = {OAMD_PAGE_ZERO_HI, calc_i.index};
			end
			OAMD_IDX_S: begin
				state_next.ea = {OAMD_PAGE_ZERO_HI, calc_i.opnd0} +
					{OAMD_PAGE_ZERO_HI, calc_i.index};
			end
			OAMD_IDX_L: begin
				state_next.ea = {calc_i.opnd0, calc_i.opnd1} +
					{OAMD_PAGE_ZERO_HI, calc_i.index};
			end
			OAMD_IND_S, OAMD_BIT_I, OAMD_BITREL_I: begin
				state_next.ea = {OAMD_PAGE_ZERO_HI, calc_i.ptr[7:0]};
			end
			OAMD_IND_L: begin
				state_next.ea = calc_i.ptr;
			end
			OAMD_IIDX_S: begin
				state_next.ea = {OAMD_PAGE_ZERO_HI, calc_i.ptr[7:0]} +
					{OAMD_PAGE_ZERO_HI, calc_i.index};
			end
			OAMD_IIDX_L: begin
				state_next.ea = calc_i.ptr + {OAMD_PAGE_ZERO_HI, calc_i.index};
			end
			OAMD_REL_D: begin
				state_next.ea = rel_add(pc_i, calc_i.opnd0);
			end
			OAMD_REL_I: begin
				state_next.ea = rel_add(pc_i, calc_i.ptr[7:0]);
			end
			default: begin
				state_next.ea = OAMD_EA_RESET;
			end
		endcase
		// Bit test-and-branch carries its displacement in the last byte
		if (calc_i.mode == OAMD_BITREL_D || calc_i.mode == OAMD_BITREL_I) begin
			state_next.target = rel_add(pc_i, calc_i.opnd1);
		end else if (calc_i.mode == OAMD_REL_D || calc_i.mode == OAMD_REL_I) begin
			state_next.target = state_next.ea;
		end
	end

	// State register
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign calc_o = state_reg;

endmodule : oamd_ea_calc

`default_nettype wire

// >>> oamd_decoder_props.sv
`timescale 1ns/100ps
`default_nettype none

module oamd_decoder_props (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Decode request
	input wire logic start_i,
	input wire oamd_pkg::oamd_mode_t mode_i,
	input wire logic rmw_i,
	// Decode result and fetch side
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic illegal_o,
	input wire logic fetch_req_o,
	input wire logic ptr_rd_o,
	input wire logic [15:0] ptr_addr_o,
	input wire oamd_pkg::oamd_family_t family_o,
	input wire logic [2:0] length_o,
	input wire logic [15:0] ea_o,
	input wire logic [15:0] target_o,
	input wire logic wait_for_interrupt_op_o,
	input wire logic halt_op_o
);
	import oamd_pkg::*;

	// -------------------------------------------------------------
	// Sequences
	// -------------------------------------------------------------
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Accepted starts only: a start while busy is dropped
	sequence s_inh_take;
		start_i && !busy_o && mode_i == OAMD_INH;
	endsequence
	sequence s_long_rmw;
		start_i && !busy_o && rmw_i && (mode_i inside {OAMD_DIR_L, OAMD_IDX_L,
			OAMD_IND_L, OAMD_IIDX_L});
	endsequence
	sequence s_quiet;
		(!fetch_req_o && !ptr_rd_o) [*3];
	endsequence

	// -------------------------------------------------------------
	// Properties
	// -------------------------------------------------------------
	a_inh_done_three: assert property (s_inh_take |-> ##3 done_o)
		else $error("inherent decode not done three cycles after start");
	a_inh_no_fetch: assert property (s_inh_take |=> s_quiet)
		else $error("inherent decode fetched operand bytes");
	a_rmw_long_flag: assert property (s_long_rmw |-> ##3 (done_o && illegal_o && ea_o == 16'h0000))
		else $error("long form with read-modify-write not flagged");
	a_rmw_no_fetch: assert property (s_long_rmw |=> s_quiet)
		else $error("refused long form still fetched");
	a_done_one_cycle: assert property (done_o |=> !done_o)
		else $error("done lasted more than one cycle");
	a_ptr_page_zero: assert property (ptr_rd_o |-> ptr_addr_o[15:8] == OAMD_PAGE_ZERO_HI)
		else $error("pointer read outside page zero");
	a_ptr_rd_pulse: assert property (ptr_rd_o |=> !ptr_rd_o)
		else $error("pointer read strobe longer than one cycle");
	a_power_op_inh: assert property ((wait_for_interrupt_op_o || halt_op_o) |->
		(done_o && family_o == OAMD_FAM_INH && !(wait_for_interrupt_op_o && halt_op_o)))
		else $error("power request outside an inherent done");
	a_inh_len_zero: assert property (done_o && family_o == OAMD_FAM_INH |-> length_o == 3'h0)
		else $error("inherent length not zero");
	a_imm_len_one: assert property (done_o && family_o == OAMD_FAM_IMM |-> length_o == 3'h1)
		else $error("immediate length not one");
	a_target_plain: assert property (done_o && family_o == OAMD_FAM_DIR |-> target_o == 16'h0000)
		else $error("branch target set for a direct mode");
endmodule : oamd_decoder_props

bind oamd_decoder oamd_decoder_props u_props (.core_clk_i, .sys_rst_i, .start_i, .mode_i,
	.rmw_i, .busy_o, .done_o, .illegal_o, .fetch_req_o, .ptr_rd_o, .ptr_addr_o, .family_o,
	.length_o, .ea_o, .target_o, .wait_for_interrupt_op_o, .halt_op_o);

`default_nettype wire

// >>> oamd_tb.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import oamd_pkg::*;

	// -------------------------------------------------------------
	// Design and stimulus
	// -------------------------------------------------------------
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic start_i = 1'b0, use_y_i = 1'b0, rmw_i = 1'b0;
	oamd_mode_t mode_i = OAMD_INH;
	oamd_inh_t inh_kind_i = OAMD_INH_OTHER;
	logic [7:0] x_i = 8'h00, y_i = 8'h00, fetch_byte_i = 8'h00, ptr_data_i = 8'h00;
	logic [15:0] pc_i = 16'h0000;
	logic fetch_valid_i = 1'b0, ptr_valid_i = 1'b0;
	logic fetch_req_o, ptr_rd_o, busy_o, done_o, illegal_o;
	logic wait_for_interrupt_op_o, halt_op_o;
	oamd_family_t family_o;
	logic [2:0] length_o;
	logic [7:0] operand_o;
	logic [15:0] ptr_addr_o, ea_o, target_o;
	int failures = 0;
	int compares = 0;
	int fidx = 0;
	int pcnt = 0;
	logic [7:0] paddr = 8'h00;
	logic [7:0] mem [256];
	logic [7:0] strm [2];
	int len_tab [17] = '{0, 1, 1, 2, 0, 1, 2, 2, 2, 2, 2, 1, 2, 1, 2, 2, 3};
	int nf_tab [17] = '{0, 1, 1, 2, 0, 1, 2, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2};
	int fam_tab [17] = '{0, 1, 2, 2, 3, 3, 3, 4, 4, 4, 4, 5, 5, 6, 6, 6, 6};

	oamd_decoder DUT (.core_clk_i, .sys_rst_i, .start_i, .mode_i, .use_y_i, .rmw_i,
		.inh_kind_i, .x_i, .y_i, .pc_i, .fetch_valid_i, .fetch_byte_i, .fetch_req_o,
		.ptr_valid_i, .ptr_data_i, .ptr_rd_o, .ptr_addr_o, .busy_o, .done_o, .illegal_o,
		.family_o, .length_o, .operand_o, .ea_o, .target_o, .wait_for_interrupt_op_o,
		.halt_op_o);

	// 50 MHz core clock
	always #10 core_clk_i = ~core_clk_i;

	// Stalling byte stream and slow pointer memory; idle lines carry junk
	always @(negedge core_clk_i) begin
		fetch_valid_i = ($urandom % 4) != 0;
		fetch_byte_i = fetch_valid_i ? strm[fidx % 2] : ~strm[fidx % 2];
		ptr_valid_i = pcnt == 1;
		ptr_data_i = ptr_valid_i ? mem[paddr] : ~mem[paddr];
	end

	// Count taken bytes; answer each pointer read after 1 to 3 cycles
	always @(posedge core_clk_i) begin
		if (fetch_req_o && fetch_valid_i) fidx <= fidx + 1;
		if (ptr_rd_o) begin
			pcnt <= 1 + $urandom % 3;
			paddr <= ptr_addr_o[7:0];
		end else if (pcnt > 0) pcnt <= pcnt - 1;
	end

	// -------------------------------------------------------------
	// Model and checks
	// -------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict

	function automatic int sx(input int b);
		return b > 127 ? b - 256 : b;
	endfunction : sx

	// One decode, begun at a falling edge; a stray start while busy
	task automatic run(input oamd_mode_t m, input logic uy, input logic rm);
		int b0, b1, p0, p1, ea, tg, n;
		logic bad;
		oamd_inh_t k;
		b0 = $urandom % 256;
		b1 = $urandom % 256;
		strm[0] = b0[7:0];
		strm[1] = b1[7:0];
		p0 = mem[b0];
		p1 = mem[(b0 + 1) % 256];
		x_i = 8'($urandom);
		y_i = 8'($urandom);
		pc_i = 16'($urandom);
		k = oamd_inh_t'($urandom % 3);
		bad = rm && (m inside {OAMD_DIR_L, OAMD_IDX_L, OAMD_IND_L, OAMD_IIDX_L});
		ea = -1;
		tg = 0;
		case (m)
			OAMD_DIR_S, OAMD_BIT_D, OAMD_BITREL_D: ea = b0;
			OAMD_DIR_L: ea = b0 * 256 + b1;
			OAMD_IDX0: ea = uy ? y_i : x_i;
			OAMD_IDX_S: ea = b0 + x_i;
			OAMD_IDX_L: ea = (b0 * 256 + b1 + x_i) % 65536;
			OAMD_IND_S, OAMD_BIT_I, OAMD_BITREL_I: ea = p0;
			OAMD_IND_L: ea = p0 * 256 + p1;
			OAMD_IIDX_S: ea = p0 + x_i;
			OAMD_IIDX_L: ea = (p0 * 256 + p1 + x_i) % 65536;
			OAMD_REL_D: tg = pc_i + sx(b0);
			OAMD_REL_I: tg = pc_i + sx(p0);
			default: ;
		endcase
		if (m inside {OAMD_BITREL_D, OAMD_BITREL_I}) tg = pc_i + sx(b1);
		if (bad) ea = 0;
		mode_i = m;
		use_y_i = uy;
		rmw_i = rm;
		inh_kind_i = k;
		start_i = 1'b1;
		fidx = 0;
		@(negedge core_clk_i);
		mode_i = oamd_mode_t'($urandom % 17);
		start_i = 1'($urandom);
		@(negedge core_clk_i);
		start_i = 1'b0;
		n = 0;
		while (done_o !== 1'b1 && n < 60) begin
			@(negedge core_clk_i);
			n++;
		end
		check("done", done_o, 1'b1);
		check("illegal", illegal_o, bad);
		check("family", family_o, fam_tab[m]);
		check("fetched", fidx, bad ? 0 : nf_tab[m]);
		if (!bad) check("length", length_o, len_tab[m] + int'(uy));
		if (ea >= 0) check("address", ea_o, ea);
		check("target", target_o, tg);
		if (m == OAMD_IMM) check("literal", operand_o, b0);
		check("wait_op", wait_for_interrupt_op_o, m == OAMD_INH && k == OAMD_INH_WAIT_INT);
		check("halt_op", halt_op_o, m == OAMD_INH && k == OAMD_INH_HALT);
	endtask : run

	// -------------------------------------------------------------
	// Sequence
	// -------------------------------------------------------------
	// All modes back to back; last rounds mark every opcode read-modify-write
	initial begin
		void'($urandom(13));
		foreach (mem[i]) mem[i] = 8'($urandom);
		repeat (10) @(negedge core_clk_i);
		sys_rst_i = 1'b0;
		check("busy", busy_o, 1'b0);
		check("reset_family", family_o, OAMD_FAM_INH);
		check("reset_address", ea_o, 16'h0000);
		for (int r = 0; r < 6; r++) begin
			for (int m = 0; m < 17; m++) begin
				run(oamd_mode_t'(m), oamd_mode_t'(m) == OAMD_IDX0 && r[0], r > 3);
			end
		end
		give_verdict();
	end

	// Hang guard, well beyond the several hundred cycles needed
	initial begin
		repeat (20000) @(posedge core_clk_i);
		failures++;
		give_verdict();
	end
endmodule : testbench

`default_nettype wire
